// file: include/counter_readout_map.svh
`ifndef COUNTER_READOUT_MAP_SVH
`define COUNTER_READOUT_MAP_SVH

// link opcodes
`define OP_READOUT       8'h96
`define OP_CTR_CMD       8'h9b
`define OP_WREN          8'h06
`define OP_WRDI          8'h04
`define OP_DPD           8'hb9
`define OP_RDP           8'hab

// counter result status values and bit positions
`define STATUS_RESET     8'h00
`define STATUS_BUSY      8'h01
`define STATUS_BUSY_BIT  0
`define STATUS_FATAL_BIT 5
`define STATUS_DONE_BIT  7

// register offsets (byte addresses)
`define ADDR_EVT         4'h0
`define ADDR_MASK        4'h4
`define ADDR_STATE       4'h8
`define ADDR_CTRL        4'hc

// event bit positions and event register width
`define EVT_READOUT      0
`define EVT_CTR_CMD      1
`define EVT_FATAL        2
`define EVT_W            3

// reset values
`define EVT_RESET        3'h0
`define MASK_RESET       3'h0
`define CTRL_RESET       1'h1

`endif

// file: include/counter_readout_pkg.sv
`default_nettype none

package counter_readout_pkg;

   // serial link decode states
   typedef enum logic [1:0]
   {
      LINK_IDLE,
      LINK_OPCODE,
      LINK_READOUT,
      LINK_SKIP
   } link_state_t;

endpackage

`default_nettype wire

// file: rtl/pin_sync.sv
`timescale 1ns/100ps
`default_nettype none

// two-flop synchroniser for a bus of independent levels
module pin_sync #(
   parameter int          WIDTH = 1,
   parameter logic [31:0] INIT  = 32'h0000_0000
) (
   input  wire logic             ref_clk,
   input  wire logic             reset_n,
   input  wire logic [WIDTH-1:0] async_in,
   output var  logic [WIDTH-1:0] sync_out
);

   logic [WIDTH-1:0] meta_q;

   if (WIDTH < 1 || WIDTH > 32)
   begin : g_chk
      $error("pin_sync: WIDTH must be 1..32");
   end

   // first stage feeds only the second stage
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         meta_q   <= INIT[WIDTH-1:0];
         sync_out <= INIT[WIDTH-1:0];
      end
      else
      begin
         meta_q   <= async_in;
         sync_out <= meta_q;
      end
   end

endmodule

`default_nettype wire

// file: rtl/counter_readout.sv
`timescale 1ns/100ps
`default_nettype none
`include "counter_readout_map.svh"

module counter_readout
   import counter_readout_pkg::*;
#(
   parameter int DATA_BITS = 384
) (
   input  wire logic                 ref_clk,
   input  wire logic                 reset_n,
   input  wire logic                 sclk,
   input  wire logic                 cs_n,
   input  wire logic                 si,
   output var  logic                 so,
   output var  logic                 so_oe_n,
   input  wire logic                 status_wr,
   input  wire logic [7:0]           status_wdata,
   input  wire logic                 fatal_err,
   input  wire logic [DATA_BITS-1:0] result_data,
   output var  logic                 ctr_cmd_start,
   output var  logic                 write_enable_latch,
   output var  logic                 deep_power_down,
   input  wire logic [3:0]           reg_addr,
   input  wire logic [31:0]          reg_wdata,
   input  wire logic                 reg_wr,
   input  wire logic                 reg_rd,
   output var  logic [31:0]          reg_rdata,
   output var  logic                 irq
);

   localparam int OW = DATA_BITS + 8;

   if (DATA_BITS < 8 || DATA_BITS % 8 != 0)
   begin : g_chk
      $error("counter_readout: DATA_BITS must be a multiple of 8");
   end

   logic              sclk_s;
   logic              cs_n_s;
   logic              si_s;
   logic              sclk_prev_q;
   logic              rise;
   logic              fall;
   logic [7:0]        opcode;
   logic              ctr_hit;
   logic              ro_hit;
   link_state_t       state_q;
   link_state_t       state_d;
   logic [2:0]        cnt_q;
   logic [2:0]        cnt_d;
   logic [6:0]        in_sh_q;
   logic [6:0]        in_sh_d;
   logic [OW-1:0]     out_sh_q;
   logic [OW-1:0]     out_sh_d;
   logic              so_d;
   logic              so_oe_n_d;
   logic              ctr_start_d;
   logic              ro_evt_q;
   logic              ro_evt_d;
   logic              wel_d;
   logic              dpd_d;
   logic [7:0]        status_q;
   logic [7:0]        status_d;
   logic              armed_q;
   logic              armed_d;
   logic [`EVT_W-1:0] evt_q;
   logic [`EVT_W-1:0] evt_d;
   logic [`EVT_W-1:0] mask_q;
   logic [`EVT_W-1:0] mask_d;
   logic              ro_en_q;
   logic              ro_en_d;
   logic [31:0]       rdata_d;
   logic              irq_d;

   // link pins cross into ref_clk; select idles high
   pin_sync #(
      .WIDTH (3),
      .INIT  (32'h0000_0002)
   ) u_sync (
      .ref_clk  (ref_clk),
      .reset_n  (reset_n),
      .async_in ({sclk, cs_n, si}),
      .sync_out ({sclk_s, cs_n_s, si_s})
   );

   // serial clock edges found from the synchronised level
   assign rise   = sclk_s & ~sclk_prev_q;
   assign fall   = ~sclk_s & sclk_prev_q;
   assign opcode = {in_sh_q, si_s};

   // link decode, shift-out and result status next values
   always_comb
   begin
      state_d     = state_q;
      cnt_d       = cnt_q;
      in_sh_d     = in_sh_q;
      out_sh_d    = out_sh_q;
      so_d        = so;
      so_oe_n_d   = so_oe_n;
      ctr_start_d = 1'b0;
      ro_evt_d    = 1'b0;
      wel_d       = write_enable_latch;
      dpd_d       = deep_power_down;
      status_d    = status_q;
      armed_d     = armed_q;
      ctr_hit     = 1'b0;
      ro_hit      = 1'b0;
      if (cs_n_s)
      begin
         state_d   = LINK_IDLE;
         cnt_d     = 3'h0;
         so_oe_n_d = 1'b1;
         so_d      = 1'b0;
      end
      else
      begin
         unique case (state_q)
            LINK_IDLE, LINK_OPCODE:
            begin
               state_d = LINK_OPCODE;
               if (rise)
               begin
                  in_sh_d = opcode[6:0];
                  cnt_d   = cnt_q + 3'h1;
                  if (cnt_q == 3'h7)
                  begin
                     state_d = LINK_SKIP;
                     if (deep_power_down)
                     begin
                        if (opcode == `OP_RDP)
                           dpd_d = 1'b0;
                     end
                     else if (opcode == `OP_READOUT && ro_en_q)
                     begin
                        ro_hit    = 1'b1;
                        state_d   = LINK_READOUT;
                        out_sh_d  = {status_q, result_data};
                        so_oe_n_d = 1'b0;
                        ro_evt_d  = 1'b1;
                     end
                     else if (opcode == `OP_CTR_CMD)
                     begin
                        ctr_hit     = 1'b1;
                        ctr_start_d = 1'b1;
                     end
                     else if (opcode == `OP_WREN)
                        wel_d = 1'b1;
                     else if (opcode == `OP_WRDI)
                        wel_d = 1'b0;
                     else if (opcode == `OP_DPD)
                        dpd_d = 1'b1;
                  end
               end
            end
            LINK_READOUT:
            begin
               // status byte then result data, msb first, on falling edges
               if (fall)
               begin
                  so_d     = out_sh_q[OW-1];
                  out_sh_d = {out_sh_q[OW-2:0], 1'b0};
               end
            end
            LINK_SKIP:
            begin
               state_d = LINK_SKIP;
            end
         endcase
      end
      // engine updates only land after a counter opcode arrived
      if (armed_q && status_wr)
         status_d = status_wdata;
      if (ctr_hit)
      begin
         status_d = `STATUS_BUSY;
         armed_d  = 1'b1;
      end
      if (fatal_err)
         status_d[`STATUS_FATAL_BIT] = 1'b1;
   end

   // link group registers; supply reset clears everything except so_oe_n, which it sets
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state_q            <= LINK_IDLE;
         sclk_prev_q        <= 1'b0;
         cnt_q              <= 3'h0;
         in_sh_q            <= 7'h00;
         out_sh_q           <= '0;
         so                 <= 1'b0;
         so_oe_n            <= 1'b1;
         ctr_cmd_start      <= 1'b0;
         ro_evt_q           <= 1'b0;
         write_enable_latch <= 1'b0;
         deep_power_down    <= 1'b0;
         status_q           <= `STATUS_RESET;
         armed_q            <= 1'b0;
      end
      else
      begin
         state_q            <= state_d;
         sclk_prev_q        <= sclk_s;
         cnt_q              <= cnt_d;
         in_sh_q            <= in_sh_d;
         out_sh_q           <= out_sh_d;
         so                 <= so_d;
         so_oe_n            <= so_oe_n_d;
         ctr_cmd_start      <= ctr_start_d;
         ro_evt_q           <= ro_evt_d;
         write_enable_latch <= wel_d;
         deep_power_down    <= dpd_d;
         status_q           <= status_d;
         armed_q            <= armed_d;
      end
   end

   // register bus: events (write one to clear), mask, state, control
   always_comb
   begin
      evt_d   = evt_q;
      mask_d  = mask_q;
      ro_en_d = ro_en_q;
      rdata_d = 32'h0000_0000;
      if (reg_wr)
      begin
         unique case (reg_addr)
            `ADDR_EVT:  evt_d   = evt_q & ~reg_wdata[`EVT_W-1:0];
            `ADDR_MASK: mask_d  = reg_wdata[`EVT_W-1:0];
            `ADDR_CTRL: ro_en_d = reg_wdata[0];
            default:    ;
         endcase
      end
      // a new event wins over a clear in the same cycle
      evt_d[`EVT_READOUT] = evt_d[`EVT_READOUT] | ro_evt_q;
      evt_d[`EVT_CTR_CMD] = evt_d[`EVT_CTR_CMD] | ctr_cmd_start;
      evt_d[`EVT_FATAL]   = evt_d[`EVT_FATAL] | fatal_err;
      if (reg_rd)
      begin
         unique case (reg_addr)
            `ADDR_EVT:   rdata_d = {29'h0, evt_q};
            `ADDR_MASK:  rdata_d = {29'h0, mask_q};
            `ADDR_STATE: rdata_d = {21'h0, armed_q, deep_power_down,
                                    write_enable_latch, status_q};
            `ADDR_CTRL:  rdata_d = {31'h0, ro_en_q};
            default:     rdata_d = 32'h0000_0000;
         endcase
      end
      irq_d = |(evt_d & mask_d);
   end

   // register group flops
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         evt_q     <= `EVT_RESET;
         mask_q    <= `MASK_RESET;
         ro_en_q   <= `CTRL_RESET;
         reg_rdata <= 32'h0000_0000;
         irq       <= 1'b0;
      end
      else
      begin
         evt_q     <= evt_d;
         mask_q    <= mask_d;
         ro_en_q   <= ro_en_d;
         reg_rdata <= rdata_d;
         irq       <= irq_d;
      end
   end

   // checks on the block's own behaviour
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);

   property p_readout_load;
      ro_hit |=> out_sh_q[OW-1 -: 8] == $past(status_q) && !so_oe_n;
   endproperty
   a_readout_load: assert property (p_readout_load)
      else $error("readout did not load the result status");

   property p_status_poweron;
      $rose(reset_n) |-> status_q == 8'h00 && !armed_q;
   endproperty
   a_status_poweron: assert property (p_status_poweron)
      else $error("status not zero after reset");

   property p_fatal_bit;
      fatal_err |=> status_q[5]
         ##1 (status_q[5] || $past(ctr_hit) || $past(status_wr));
   endproperty
   a_fatal_bit: assert property (p_fatal_bit)
      else $error("fatal error did not set status bit 5");

   property p_status_frozen;
      !armed_q && !ctr_hit && !fatal_err |=> status_q == $past(status_q);
   endproperty
   a_status_frozen: assert property (p_status_frozen)
      else $error("status changed before a counter opcode");

   property p_standby;
      $rose(reset_n) |-> !deep_power_down;
   endproperty
   a_standby: assert property (p_standby)
      else $error("device not in standby after reset");

   property p_wel_clear;
      $rose(reset_n) |-> !write_enable_latch;
   endproperty
   a_wel_clear: assert property (p_wel_clear)
      else $error("write enable latch set after reset");

   property p_reset_hold;
      @(posedge ref_clk) disable iff (1'b0)
      !reset_n |=> so_oe_n && !ctr_cmd_start && !irq && state_q == LINK_IDLE;
   endproperty
   a_reset_hold: assert property (p_reset_hold)
      else $error("logic active during supply reset");

   property p_busy_code;
      ctr_hit && !fatal_err |=> status_q == 8'h01
         ##1 (!status_q[7] || $past(status_wr));
   endproperty
   a_busy_code: assert property (p_busy_code)
      else $error("counter opcode did not flag busy");

   property p_msb_first;
      state_q == LINK_READOUT && fall && !cs_n_s
         |=> so == $past(out_sh_q[OW-1]) && !so_oe_n;
   endproperty
   a_msb_first: assert property (p_msb_first)
      else $error("readout bit out of order");

   c_readout: cover property (ro_hit ##[1:200] fall);
   c_ctr_cmd: cover property (ctr_hit ##[1:50] status_wr);
   c_irq:     cover property ($rose(irq));
   c_fatal:   cover property (fatal_err && armed_q);

endmodule

`default_nettype wire

// file: dv/link_host_model.sv
`timescale 1ns/100ps
`default_nettype none

// host end of the serial link: mode 0, clock idle low, 320 ns bit time
module link_host_model (
   output var  logic sclk,
   output var  logic cs_n,
   output var  logic si,
   input  wire logic so,
   input  wire logic so_oe_n
);
   // select stays inactive until the first frame
   initial
   begin
      sclk = 1'b0;
      cs_n = 1'b1;
      si   = 1'b0;
   end

   // opcode out msb first, then n bits captured late in each high phase
   task automatic frame(input logic [7:0] op, input int n,
                        output logic [31:0] rx, output int n_drv);
      rx    = '0;
      n_drv = 0;
      #7 cs_n = 1'b0;
      #160;
      for (int i = 0; i < 8 + n; i++)
      begin
         si = (i < 8) ? op[7-i] : ~si; // data line not held after opcode
         #160 sclk = 1'b1;
         #150;
         if (i >= 8)
         begin
            rx    = {rx[30:0], so_oe_n ? 1'b1 : so}; // released line pulls up
            n_drv += (so_oe_n === 1'b0);
         end
         #10 sclk = 1'b0;
      end
      #160 cs_n = 1'b1;
      si = ~si;
      #400;
   endtask
endmodule

`default_nettype wire

// file: dv/counter_readout_tb.sv
`timescale 1ns/100ps
`default_nettype none
`include "counter_readout_map.svh"

module counter_readout_tb;
   localparam int DW = 16;
   logic          ref_clk      = 1'b0;
   logic          reset_n      = 1'b0;
   logic          status_wr    = 1'b0;
   logic [7:0]    status_wdata = 8'h00;
   logic          fatal_err    = 1'b0;
   logic [DW-1:0] result_data  = '0;
   logic [3:0]    reg_addr     = 4'h0;
   logic [31:0]   reg_wdata    = 32'h0;
   logic          reg_wr       = 1'b0;
   logic          reg_rd       = 1'b0;
   logic [31:0]   reg_rdata;
   wire logic     sclk, cs_n, si, so, so_oe_n, irq;
   wire logic     ctr_cmd_start, write_enable_latch, deep_power_down;
   logic [31:0]   rx;
   logic [7:0]    m_status     = 8'h00;
   bit            armed        = 1'b0;
   int            nd, n_fail, check_count, cyc, n_start;
   int            seed         = 35917;

   always #20 ref_clk = ~ref_clk;

   counter_readout #(.DATA_BITS(DW)) i_dut (
      .ref_clk(ref_clk), .reset_n(reset_n), .sclk(sclk), .cs_n(cs_n),
      .si(si), .so(so), .so_oe_n(so_oe_n), .status_wr(status_wr),
      .status_wdata(status_wdata), .fatal_err(fatal_err),
      .result_data(result_data), .ctr_cmd_start(ctr_cmd_start),
      .write_enable_latch(write_enable_latch),
      .deep_power_down(deep_power_down), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_rdata(reg_rdata), .irq(irq));

   link_host_model i_host (
      .sclk(sclk), .cs_n(cs_n), .si(si), .so(so), .so_oe_n(so_oe_n));

   // counts start pulses and cuts a hang short
   always @(posedge ref_clk)
   begin
      n_start += (ctr_cmd_start === 1'b1);
      cyc++;
      if (cyc == 60000)
      begin
         n_fail++;
         results();
      end
   end

   task automatic results();
      $display("checks %0d mismatches %0d", check_count, n_fail);
      if (n_fail == 0 && check_count > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask

   task automatic chk(input string nm, input logic [31:0] e,
                      input logic [31:0] g);
      check_count++;
      if (g !== e)
      begin
         $display("MISMATCH %s expected %h seen %h", nm, e, g);
         n_fail++;
      end
   endtask

   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge ref_clk);
      reg_wr    <= 1'b1;
      reg_addr  <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   // read data stand only in the cycle after the strobe
   task automatic rd(input logic [3:0] a, input logic [31:0] e,
                     input logic [31:0] m);
      @(posedge ref_clk);
      reg_rd   <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 chk("reg_rdata", e, reg_rdata & m);
      @(posedge ref_clk);
      #1 chk("rdata_idle", 32'h0, reg_rdata);
   endtask

   // engine result write, kept by the model only once armed
   task automatic engine(input logic [7:0] v);
      @(posedge ref_clk);
      status_wr    <= 1'b1;
      status_wdata <= v;
      @(posedge ref_clk);
      status_wr <= 1'b0;
      if (armed)
         m_status = v;
   endtask

   task automatic pulse_fatal();
      @(posedge ref_clk);
      fatal_err <= 1'b1;
      @(posedge ref_clk);
      fatal_err <= 1'b0;
      m_status[5] = 1'b1;
   endtask

   // readout frame; live selects answer or a released, pulled-up line
   task automatic ro(input bit live);
      i_host.frame(8'h96, 8 + DW, rx, nd);
      chk("readout", live ? {8'h00, m_status, result_data}
                          : 32'((1 << (8 + DW)) - 1), rx);
      chk("drive_bits", live ? 32'(8 + DW) : 32'h0, 32'(nd));
   endtask

   function automatic logic [31:0] st(input logic [1:0] wd);
      return {22'h0, wd, m_status};
   endfunction

   // main sequence
   initial
   begin
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      rd(`ADDR_STATE, 32'h0, 32'h3ff);
      chk("pins", 32'h0, {30'h0, write_enable_latch, deep_power_down});
      rd(`ADDR_MASK, 32'h0, 32'h7);
      rd(`ADDR_CTRL, 32'h1, 32'h1);
      wr(4'h2, 32'hffff_ffff);
      rd(4'h2, 32'h0, 32'hffff_ffff);
      result_data <= DW'($random(seed));
      ro(1'b1);
      engine(8'h80);
      ro(1'b1);
      i_host.frame(8'h9b, 0, rx, nd);
      armed    = 1'b1;
      m_status = 8'h01;
      chk("ctr_start", 32'h1, 32'(n_start));
      ro(1'b1);
      engine(8'h80);
      ro(1'b1);
      engine(8'($random(seed)));
      result_data <= DW'($random(seed));
      ro(1'b1);
      pulse_fatal();
      ro(1'b1);
      wr(`ADDR_EVT, 32'h7);
      rd(`ADDR_EVT, 32'h0, 32'h7);
      wr(`ADDR_MASK, 32'h4);
      pulse_fatal();
      repeat (3) @(posedge ref_clk);
      #1 chk("irq", 32'h1, {31'h0, irq});
      rd(`ADDR_EVT, 32'h4, 32'h7);
      wr(`ADDR_EVT, 32'h4);
      ro(1'b1);
      chk("irq", 32'h0, {31'h0, irq});
      rd(`ADDR_EVT, 32'h1, 32'h7);
      i_host.frame(8'h06, 0, rx, nd);
      chk("wel_pin", 32'h1, {31'h0, write_enable_latch});
      rd(`ADDR_STATE, st(2'b01), 32'h3ff);
      i_host.frame(8'h04, 0, rx, nd);
      i_host.frame(8'hb9, 0, rx, nd);
      rd(`ADDR_STATE, st(2'b10), 32'h3ff);
      chk("dpd_pin", 32'h1, {31'h0, deep_power_down});
      ro(1'b0);
      i_host.frame(8'hab, 0, rx, nd);
      wr(`ADDR_CTRL, 32'h0);
      ro(1'b0);
      rd(`ADDR_STATE, st(2'b00), 32'h3ff);
      // latch and power-down set so the reset below must clear them
      i_host.frame(8'h06, 0, rx, nd);
      i_host.frame(8'hb9, 0, rx, nd);
      @(posedge ref_clk);
      reset_n <= 1'b0;
      i_host.frame(8'h9b, 0, rx, nd);
      @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (3) @(posedge ref_clk);
      m_status = 8'h00;
      armed    = 1'b0;
      chk("ctr_start", 32'h1, 32'(n_start));
      rd(`ADDR_STATE, 32'h0, 32'h3ff);
      chk("pins", 32'h0, {30'h0, write_enable_latch, deep_power_down});
      engine(8'h80);
      ro(1'b1);
      results();
   end
endmodule

`default_nettype wire
